// ===== logic/temp_format_pkg.sv
/*
  Constants shared by the temperature result formatter: register byte
  offsets on the APB slave, field positions, status bit layout, output
  encodings and reset values.
  Assumes a 32-bit APB with byte addresses; each register is one word.
*/
// Summary of operation
// - reset selects standard range for both channels
// - standard range: negative result gives integer zero
// - standard range: above 127 saturates at 7F
// - config bit 2 selects standard or extended
// - range change applies from next conversion only
// - extended range adds offset of 64
// - extended codes span minus 64 to 191
// - limits never reformatted; host rewrites them
// - high byte holds whole degrees, one per count
// - low byte holds the fractional degrees
// - remote channel always sixteenth-degree resolution
// - local resolution half to sixteenth, two bits
// - high or low limit crossing drives alarm
// - separate thermal limits drive thermal flag
// - alarm and thermal outputs only pull low
package temp_format_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CONFIG     = 12'h000;
  localparam logic [11:0] OFS_RESOLUTION = 12'h004;
  localparam logic [11:0] OFS_LOCAL_RES  = 12'h008;
  localparam logic [11:0] OFS_REMOTE_RES = 12'h00c;
  localparam logic [11:0] OFS_LOCAL_HI   = 12'h010;
  localparam logic [11:0] OFS_LOCAL_LO   = 12'h014;
  localparam logic [11:0] OFS_REMOTE_HI  = 12'h018;
  localparam logic [11:0] OFS_REMOTE_LO  = 12'h01c;
  localparam logic [11:0] OFS_LOCAL_TH   = 12'h020;
  localparam logic [11:0] OFS_REMOTE_TH  = 12'h024;
  localparam logic [11:0] OFS_STATUS     = 12'h028;
  localparam logic [11:0] OFS_MASK       = 12'h02c;
  localparam logic [11:0] OFS_PINS       = 12'h030;

  // field positions
  localparam int CFG_RANGE_BIT  = 2;
  localparam int RES_MSB_BIT    = 1;
  localparam int RES_LSB_BIT    = 0;
  localparam int PIN_ALARM_BIT  = 0;
  localparam int PIN_THERMAL_FLAG_OUTPUT_BIT  = 1;

  // channel indices
  localparam int CH_LOCAL  = 0;
  localparam int CH_REMOTE = 1;
  localparam int NUM_CH    = 2;

  // status bits: per channel high, low, thermal, conversion done
  localparam int STAT_W     = 8;
  localparam int STAT_HI    = 0;
  localparam int STAT_LO    = 2;
  localparam int STAT_TH    = 4;
  localparam int STAT_DONE  = 6;

  // result encoding
  localparam int FRAC_BITS  = 4;
  localparam int EXT_OFFSET = 64;
  localparam int STD_MAX    = 127;
  localparam int EXT_MAX    = 255;
  localparam logic [3:0] MASK_HALF    = 4'h8;
  localparam logic [3:0] MASK_QUARTER = 4'hc;
  localparam logic [3:0] MASK_EIGHTH  = 4'he;
  localparam logic [3:0] MASK_FULL    = 4'hf;

  // local resolution field codes
  localparam logic [1:0] RES_HALF    = 2'h0;
  localparam logic [1:0] RES_QUARTER = 2'h1;
  localparam logic [1:0] RES_EIGHTH  = 2'h2;
  localparam logic [1:0] RES_FULL    = 2'h3;

  // reset values
  localparam logic [7:0]  RST_CONFIG = 8'h00;
  localparam logic [1:0]  RST_RES    = RES_FULL;
  localparam logic [15:0] RST_RESULT = 16'h0000;

endpackage

// ===== logic/temperature_result_formatter.sv
/*
  Temperature result formatter: turns raw signed conversion results of
  the local and remote channels into two-byte register values, keeps
  them behind an APB slave, compares them against programmed limits and
  drives an open-drain alarm pin, an open-drain thermal flag pin and a
  level interrupt.
  Assumes the converter delivers one signed result in sixteenths of a
  degree per one-cycle conv_valid pulse, synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module temperature_result_formatter
  import temp_format_pkg::*;
#(
  parameter int         TEMP_W       = 16,
  parameter logic [7:0] RST_LIMIT_HI = 8'h7f,
  parameter logic [7:0] RST_LIMIT_LO = 8'h00,
  parameter logic [7:0] RST_LIMIT_TH = 8'h7f
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              conv_valid,
  input  wire logic              conv_remote,
  input  wire logic [TEMP_W-1:0] conv_temp,
  input  wire logic              alarm_in,
  output logic                   alarm_out,
  output logic                   alarm_oe,
  input  wire logic              thermal_flag_output_in,
  output logic                   thermal_flag_output_out,
  output logic                   thermal_flag_output_oe,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // fraction mask for a local resolution code
  function automatic logic [3:0] res_mask(input logic [1:0] code);
    logic [3:0] m;
    m = MASK_FULL;
    unique case (code)
      RES_HALF:    m = MASK_HALF;
      RES_QUARTER: m = MASK_QUARTER;
      RES_EIGHTH:  m = MASK_EIGHTH;
      RES_FULL:    m = MASK_FULL;
    endcase
    return m;
  endfunction

  // raw signed sixteenths to {integer byte, fraction byte}
  function automatic logic [15:0] fmt_result(
    input logic [TEMP_W-1:0] raw,
    input logic              ext,
    input logic [3:0]        mask
  );
    logic signed [TEMP_W-1:0] whole;
    logic signed [TEMP_W-1:0] code;
    logic signed [TEMP_W-1:0] top;
    logic [15:0]              r;
    whole = signed'(raw) >>> FRAC_BITS;
    code  = whole + (ext ? TEMP_W'(EXT_OFFSET) : '0);
    top   = ext ? TEMP_W'(EXT_MAX) : TEMP_W'(STD_MAX);
    if (code < 0) begin
      r = 16'h0000;
    end else if (code > top) begin
      r = {top[7:0], 8'h00};
    end else begin
      // fraction sits in the upper nibble, lower nibble zero
      r = {code[7:0], raw[FRAC_BITS-1:0] & mask, 4'h0};
    end
    return r;
  endfunction

  // register read selection
  function automatic logic [31:0] pick(input logic [31:0] v, input logic hit);
    return hit ? v : 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]        config_reg;
  logic [1:0]        resolution;
  logic [15:0]       result   [NUM_CH];
  logic [7:0]        limit_hi [NUM_CH];
  logic [7:0]        limit_lo [NUM_CH];
  logic [7:0]        limit_th [NUM_CH];
  logic [NUM_CH-1:0] over_hi;
  logic [NUM_CH-1:0] under_lo;
  logic [NUM_CH-1:0] over_th;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire logic wr_en   = psel & penable & pwrite;
  wire logic setup   = psel & ~penable;
  wire logic hit_cfg = paddr == OFS_CONFIG;
  wire logic hit_res = paddr == OFS_RESOLUTION;
  wire logic hit_lr  = paddr == OFS_LOCAL_RES;
  wire logic hit_rr  = paddr == OFS_REMOTE_RES;
  wire logic hit_lh  = paddr == OFS_LOCAL_HI;
  wire logic hit_ll  = paddr == OFS_LOCAL_LO;
  wire logic hit_rh  = paddr == OFS_REMOTE_HI;
  wire logic hit_rl  = paddr == OFS_REMOTE_LO;
  wire logic hit_lt  = paddr == OFS_LOCAL_TH;
  wire logic hit_rt  = paddr == OFS_REMOTE_TH;
  wire logic hit_st  = paddr == OFS_STATUS;
  wire logic hit_mk  = paddr == OFS_MASK;
  wire logic hit_pin = paddr == OFS_PINS;
  wire logic mapped  = hit_cfg | hit_res | hit_lr | hit_rr | hit_lh
                     | hit_ll | hit_rh | hit_rl | hit_lt | hit_rt
                     | hit_st | hit_mk | hit_pin;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire logic [31:0] rd_value =
      pick({24'h0, config_reg}, hit_cfg)
    | pick({30'h0, resolution}, hit_res)
    | pick({16'h0, result[CH_LOCAL]}, hit_lr)
    | pick({16'h0, result[CH_REMOTE]}, hit_rr)
    | pick({24'h0, limit_hi[CH_LOCAL]}, hit_lh)
    | pick({24'h0, limit_lo[CH_LOCAL]}, hit_ll)
    | pick({24'h0, limit_hi[CH_REMOTE]}, hit_rh)
    | pick({24'h0, limit_lo[CH_REMOTE]}, hit_rl)
    | pick({24'h0, limit_th[CH_LOCAL]}, hit_lt)
    | pick({24'h0, limit_th[CH_REMOTE]}, hit_rt)
    | pick({24'h0, status}, hit_st)
    | pick({24'h0, mask}, hit_mk)
    | pick({30'h0, thermal_flag_output_in, alarm_in}, hit_pin);

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration and resolution

  // range bit is read only when a conversion is formatted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= RST_CONFIG;
    end else if (wr_en & hit_cfg) begin
      config_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resolution <= RST_RES;
    end else if (wr_en & hit_res) begin
      resolution <= {pwdata[RES_MSB_BIT], pwdata[RES_LSB_BIT]};
    end
  end

  // limits are stored as written and never reformatted on range change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_hi <= '{default: RST_LIMIT_HI};
      limit_lo <= '{default: RST_LIMIT_LO};
      limit_th <= '{default: RST_LIMIT_TH};
    end else if (wr_en) begin
      if (hit_lh) limit_hi[CH_LOCAL]  <= pwdata[7:0];
      if (hit_ll) limit_lo[CH_LOCAL]  <= pwdata[7:0];
      if (hit_rh) limit_hi[CH_REMOTE] <= pwdata[7:0];
      if (hit_rl) limit_lo[CH_REMOTE] <= pwdata[7:0];
      if (hit_lt) limit_th[CH_LOCAL]  <= pwdata[7:0];
      if (hit_rt) limit_th[CH_REMOTE] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion formatting and comparison

  wire logic       ext_range = config_reg[CFG_RANGE_BIT];
  wire logic [31:0] conv_ch  = conv_remote ? CH_REMOTE : CH_LOCAL;
  // remote always keeps every fraction bit
  wire logic [3:0] frac_mask = conv_remote ? MASK_FULL
                                           : res_mask(resolution);
  wire logic [15:0] next_result = fmt_result(conv_temp, ext_range, frac_mask);
  wire logic [7:0]  next_whole  = next_result[15:8];

  // per-channel storage; stored values never rewritten on range change
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      wire logic take = conv_valid & (conv_ch == c);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          result[c]   <= RST_RESULT;
          over_hi[c]  <= 1'b0;
          under_lo[c] <= 1'b0;
          over_th[c]  <= 1'b0;
        end else if (take) begin
          result[c]   <= next_result;
          over_hi[c]  <= next_whole > limit_hi[c];
          under_lo[c] <= next_whole < limit_lo[c];
          over_th[c]  <= next_whole > limit_th[c];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status, mask and interrupt

  // events of this cycle; a new event beats a same-cycle clear
  wire logic [NUM_CH-1:0] done_ev = {conv_valid & conv_remote,
                                     conv_valid & ~conv_remote};
  wire logic [NUM_CH-1:0] hi_ev   = done_ev & {2{next_whole > 8'h00}}
                                  & {next_whole > limit_hi[CH_REMOTE],
                                     next_whole > limit_hi[CH_LOCAL]};
  wire logic [NUM_CH-1:0] lo_ev   = done_ev
                                  & {next_whole < limit_lo[CH_REMOTE],
                                     next_whole < limit_lo[CH_LOCAL]};
  wire logic [NUM_CH-1:0] th_ev   = done_ev
                                  & {next_whole > limit_th[CH_REMOTE],
                                     next_whole > limit_th[CH_LOCAL]};
  wire logic [STAT_W-1:0] set_ev  = {done_ev, th_ev, lo_ev, hi_ev};
  wire logic [STAT_W-1:0] clr     = (wr_en & hit_st) ? pwdata[STAT_W-1:0]
                                                     : '0;
  wire logic [STAT_W-1:0] next_status = (status & ~clr) | set_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (wr_en & hit_mk) begin
      mask <= pwdata[STAT_W-1:0];
    end
  end

  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////
  // open-drain pins: data is always low, only the enable moves

  // comparator state is level: pin released once the latest result of both channels is back in range
  assign alarm_out               = 1'b0;
  assign alarm_oe                = |(over_hi | under_lo);
  assign thermal_flag_output_out = 1'b0;
  assign thermal_flag_output_oe  = |over_th;

endmodule

`default_nettype wire

// ===== bench/pin_pullup.sv
/*
  Open-drain pin network for the alarm and thermal flag lines.
  Assumes oe high means the formatter sinks the pin; other_low stands
  for any other wired-or device on the same lines.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_pullup (
  input  wire logic alarm_oe,
  input  wire logic thermal_oe,
  input  wire logic other_low,
  output logic      alarm_pin,
  output logic      thermal_pin
);
  // pull-up wins unless some party sinks the line
  assign alarm_pin   = !(alarm_oe || other_low);
  assign thermal_pin = !(thermal_oe || other_low);
endmodule
`default_nettype wire

// ===== bench/formatter_sva.sv
/*
  Port checker for the temperature result formatter.
  Assumes zero-wait APB and results laid out as in the package.
*/
`timescale 1ns/10ps
`default_nettype none
module formatter_sva
  import temp_format_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_valid,
  input wire logic        conv_remote,
  input wire logic        alarm_out,
  input wire logic        alarm_oe,
  input wire logic        thermal_flag_output_out,
  input wire logic        thermal_flag_output_oe,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       rng;
  logic [1:0] ext;
  wire        acc = psel && penable;
  wire        rd_res = acc && !pwrite && paddr[11:3] == 9'h001;
  //////////////////////////////////////////////////////////////////////
  // range in force, and range each stored result was made under
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rng <= 1'b0;
      ext <= 2'b00;
    end else begin
      if (acc && pwrite && paddr == OFS_CONFIG)
        rng <= pwdata[CFG_RANGE_BIT];
      if (conv_valid)
        ext[conv_remote] <= rng;
    end
  end
  //////////////////////////////////////////////////////////////////////
  outs_low_a: assert property (!alarm_out && !thermal_flag_output_out)
    else $error("open-drain data not low");
  std_clamp_a: assert property (
    rd_res && !$past(ext[paddr[2]]) |-> prdata[15:8] <= 8'h7f)
    else $error("standard result above 7f");
  frac_nibble_a: assert property (
    rd_res |-> prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0)
    else $error("result low nibble or upper bits set");
  alarm_cause_a: assert property ($changed(alarm_oe) |-> $past(conv_valid))
    else $error("alarm moved without conversion");
  thermal_flag_output_cause_a: assert property (
    $changed(thermal_flag_output_oe) |-> $past(conv_valid))
    else $error("thermal flag moved without conversion");
  irq_cause_a: assert property (
    $changed(irq) |-> $past(conv_valid || acc && pwrite))
    else $error("irq moved without cause");
  err_map_a: assert property (
    acc && paddr > OFS_PINS |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  ok_map_a: assert property (
    acc && paddr <= OFS_PINS && paddr[1:0] == 2'b00 |-> pready && !pslverr)
    else $error("mapped access refused");
endmodule
bind temperature_result_formatter formatter_sva formatter_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
  .conv_remote(conv_remote), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
  .thermal_flag_output_out(thermal_flag_output_out),
  .thermal_flag_output_oe(thermal_flag_output_oe), .irq(irq));
`default_nettype wire

// ===== bench/testbench.sv
/*
  Self-checking bench for the temperature result formatter.
  Assumes zero-wait APB slave and open-drain pins with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import temp_format_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        conv_valid, conv_remote, alarm_oe, th_oe, al_pin, th_pin;
  logic        other_low, irq;
  logic [15:0] conv_temp;
  int          bad_count, samples_checked;
  logic [15:0] temps [9] = '{16'h0198, 16'hffb0, 16'h0c80, 16'hfc00,
    16'h0bff, 16'h0000, 16'h07ff, 16'h0800, 16'hfbf0};
  logic [3:0]  masks [4] = '{MASK_HALF, MASK_QUARTER, MASK_EIGHTH, MASK_FULL};

  temperature_result_formatter temperature_result_formatter_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
    .conv_remote(conv_remote), .conv_temp(conv_temp), .alarm_in(al_pin),
    .alarm_out(), .alarm_oe(alarm_oe), .thermal_flag_output_in(th_pin),
    .thermal_flag_output_out(), .thermal_flag_output_oe(th_oe), .irq(irq));
  pin_pullup pin_pullup_i (.alarm_oe(alarm_oe), .thermal_oe(th_oe),
    .other_low(other_low), .alarm_pin(al_pin), .thermal_pin(th_pin));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task results;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, bounded
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        results();
      end
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask

  // one conversion pulse; #1 lets that edge's updates land
  task cv(input logic r, input logic [15:0] t);
    @(posedge pclk);
    conv_valid <= 1;
    conv_remote <= r;
    conv_temp <= t;
    @(posedge pclk);
    conv_valid <= 0;
    #1;
  endtask

  // expected word: whole degrees clamped, fraction masked to resolution
  function automatic logic [31:0] fmt(input logic ext,
      input logic [15:0] t, input logic [3:0] m);
    int w;
    w = $signed(t) >>> 4;
    if (ext)
      w = w + EXT_OFFSET;
    if (w < 0)
      return 32'h0;
    if (w > (ext ? EXT_MAX : STD_MAX))
      return ext ? 32'hff00 : 32'h7f00;
    return {16'h0, w[7:0], t[3:0] & m, 4'h0};
  endfunction
  //////////////////////////////////////////////////////////////////////
  task reset_state;
    bus(0, OFS_CONFIG, 0);
    chk(rdata, 0);
    bus(0, OFS_RESOLUTION, 0);
    chk(rdata, {30'h0, RST_RES});
    chk({29'h0, alarm_oe, th_oe, irq}, 0);
    bus(0, OFS_REMOTE_RES, 0);
    chk(rdata, 0);
  endtask

  task formats(input logic ext);
    for (int i = 0; i < 9; i++) begin
      for (int c = 0; c < 2; c++) begin
        cv(c[0], temps[i]);
        bus(0, c[0] ? OFS_REMOTE_RES : OFS_LOCAL_RES, 0);
        chk(rdata, fmt(ext, temps[i], 4'hf));
      end
    end
  endtask

  // host rewrites every limit in the newly selected range format
  task relimit(input logic e);
    for (int a = 'h10; a <= 'h24; a += 4)
      bus(1, a[11:0], (a == 'h14 || a == 'h1c) ? (e ? 'h40 : 'h0)
                                                : (e ? 'hbf : 'h7f));
  endtask

  // other config bits must not switch range; old result stays as stored
  task range_switch;
    bus(1, OFS_CONFIG, 32'hfb);
    cv(0, 16'h0c80);
    bus(0, OFS_LOCAL_RES, 0);
    chk(rdata, 32'h7f00);
    cv(0, 16'hfe70);
    bus(1, OFS_CONFIG, 32'h04);
    bus(0, OFS_LOCAL_RES, 0);
    chk(rdata, 0);
    bus(0, OFS_LOCAL_HI, 0);
    chk(rdata, 32'h7f);
    relimit(1);
    formats(1);
    bus(1, OFS_CONFIG, 0);
    relimit(0);
  endtask

  task resolution;
    for (int c = 0; c < 4; c++) begin
      bus(1, OFS_RESOLUTION, c);
      cv(0, 16'h019f);
      cv(1, 16'h019f);
      bus(0, OFS_LOCAL_RES, 0);
      chk(rdata, fmt(0, 16'h019f, masks[c]));
      bus(0, OFS_REMOTE_RES, 0);
      chk(rdata, 32'h19f0);
    end
  endtask

  task alarms;
    bus(1, OFS_STATUS, 32'hff);
    bus(1, OFS_LOCAL_HI, 32'h20);
    bus(1, OFS_LOCAL_TH, 32'h28);
    cv(0, 16'h0320);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'hc);
    chk({31'h0, irq}, 0);
    bus(0, OFS_STATUS, 0);
    chk(rdata, 32'h51);
    bus(1, OFS_MASK, 32'h01);
    chk({31'h0, irq}, 1);
    bus(1, OFS_STATUS, 32'h01);
    chk({31'h0, irq}, 0);
    bus(1, OFS_LOCAL_LO, 32'h10);
    cv(0, 16'h0050);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'h9);
    bus(0, OFS_PINS, 0);
    chk(rdata, 32'h2);
    cv(0, 16'h0190);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'h3);
    @(posedge pclk);
    other_low <= 1;
    bus(0, OFS_PINS, 0);
    chk(rdata, 0);
    @(posedge pclk);
    other_low <= 0;
    bus(1, OFS_LOCAL_RES, 32'h1234);
    bus(0, OFS_LOCAL_RES, 0);
    chk(rdata, 32'h1900);
    bus(0, 12'h100, 0);
    chk({rerr, rdata[30:0]}, 32'h80000000);
  endtask

  // remote limits drive the same pins and their own status bits
  task remote_limits;
    bus(1, OFS_STATUS, 32'hff);
    bus(1, OFS_REMOTE_HI, 32'h30);
    bus(1, OFS_REMOTE_LO, 32'h08);
    bus(1, OFS_REMOTE_TH, 32'h40);
    cv(1, 16'h0480);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'hc);
    cv(1, 16'h0040);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'h9);
    cv(1, 16'h0200);
    chk({28'h0, alarm_oe, th_oe, al_pin, th_pin}, 32'h3);
    bus(0, OFS_STATUS, 0);
    chk(rdata, 32'haa);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    samples_checked = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    conv_valid = 0;
    conv_remote = 0;
    conv_temp = 0;
    other_low = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    reset_state();
    formats(0);
    range_switch();
    resolution();
    alarms();
    remote_limits();
    results();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
